/* shared/sclint_consts.vh */
// Constants for the configuration loader with frame integrity checking
`ifndef SCLINT_CONSTS_VH
`define SCLINT_CONSTS_VH
`define SCLINT_ADDR_W 18
`define SCLINT_ADDR_FIRST 18'h00000
`define SCLINT_ADDR_LAST 18'h3ffff
`define SCLINT_CRC_W 16
`define SCLINT_CRC_POLY 16'h8005
`define SCLINT_CRC_INIT 16'h0000
`define SCLINT_FRAME_BYTES 16'h0010
`define SCLINT_INIT_CYCLES 8'h10
`define SCLINT_MODE_UP 1'b0
`define SCLINT_MODE_DOWN 1'b1
`define SCLINT_ST_IDLE 3'h0
`define SCLINT_ST_DATA 3'h1
`define SCLINT_ST_CRCHI 3'h2
`define SCLINT_ST_CRCLO 3'h3
`define SCLINT_ST_INIT 3'h4
`define SCLINT_ST_USER 3'h5
`define SCLINT_ST_ERROR 3'h6
`endif

/* testbench/sclint_loader_sva.sv */
// Port checker for the configuration loader
module sclint_loader_sva #(
  parameter ADDR_W = 18
) (
  input wire clk_sys, // Clock
  input wire rst_b, // Reset, active low
  input wire configRequestN, // Request, active low
  input wire countDownMode, // Count direction
  input wire supplyOk, // Supply good
  input wire [7:0] memData, // Memory byte
  input wire [ADDR_W-1:0] memAddr, // Memory address
  input wire memRead, // Fetching
  input wire [7:0] cfgByte, // Stored byte
  input wire cfgByteValid, // Stored byte pulse
  input wire userMode, // User mode
  input wire configDone, // Load finished
  input wire configErrorFlagNOut, // Error pin level
  input wire configErrorFlagNOe // Error pin enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_halted;
    configErrorFlagNOe && !memRead;
  endsequence
  property p_upStep;
    memRead && $past(memRead) && !countDownMode && $stable(countDownMode) &&
      $past(memAddr) != {ADDR_W{1'b1}}
      |-> memAddr == $past(memAddr) + 1'b1;
  endproperty
  a_upStep: assert property (p_upStep) else $error("bad up step");
  property p_downStep;
    memRead && $past(memRead) && countDownMode && $stable(countDownMode) &&
      $past(memAddr) != {ADDR_W{1'b0}}
      |-> memAddr == $past(memAddr) - 1'b1;
  endproperty
  a_downStep: assert property (p_downStep) else $error("bad down");
  property p_upStart;
    $rose(memRead) && !countDownMode |-> memAddr == {ADDR_W{1'b0}};
  endproperty
  a_upStart: assert property (p_upStart) else $error("bad up start");
  property p_downStart;
    $rose(memRead) && countDownMode |-> memAddr == {ADDR_W{1'b1}};
  endproperty
  a_downStart: assert property (p_downStart) else $error("bad start");
  property p_errHold;
    configErrorFlagNOe && configRequestN |=> s_halted;
  endproperty
  a_errHold: assert property (p_errHold) else $error("error lost");
  property p_supply;
    !supplyOk && configRequestN |=> s_halted;
  endproperty
  a_supply: assert property (p_supply) else $error("no supply halt");
  property p_noUser;
    configErrorFlagNOe |-> !userMode && !configDone && !configErrorFlagNOut;
  endproperty
  a_noUser: assert property (p_noUser) else $error("user in error");
  property p_clear;
    !configRequestN |=> !configErrorFlagNOe && !memRead;
  endproperty
  a_clear: assert property (p_clear) else $error("error not cleared");
endmodule // sclint_loader_sva

bind sclint_loader sclint_loader_sva #(.ADDR_W(ADDR_W)) u_sva (.clk_sys,
  .rst_b, .configRequestN, .countDownMode, .supplyOk, .memData, .memAddr,
  .memRead, .cfgByte, .cfgByteValid, .userMode, .configDone,
  .configErrorFlagNOut, .configErrorFlagNOe);

/* testbench/sclint_mem_model.sv */
// Byte-wide configuration memory holding framed data with check bytes
module sclint_mem_model (
  input wire [17:0] memAddr, // Address from loader
  input wire memRead, // Loader fetching
  input wire countDownMode, // Stream stored from the top down
  input wire corrupt, // Damage every check low byte
  output logic [7:0] memData // Byte at address
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] off;
  logic [15:0] crc;
  always_comb begin
    off = countDownMode ? ~memAddr : memAddr;
    crc = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      crc = crc ^ {8'(off / 18 * 18 + i) ^ 8'h3c, 8'h00};
      for (int j = 0; j < 8; j++)
        crc = crc[15] ? (crc << 1) ^ 16'h8005 : crc << 1;
    end
    if (off % 18 < 16)
      memData = 8'(off) ^ 8'h3c;
    else if (off % 18 == 16)
      memData = crc[15:8];
    else
      memData = crc[7:0] ^ {7'h00, corrupt};
    // Deselected: never show a stale byte
    if (!memRead)
      memData = ~memData;
  end
endmodule // sclint_mem_model

/* testbench/test_sclint_loader.sv */
// Self-checking bench for the configuration loader
`include "sclint_consts.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module test_sclint_loader;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_b, configRequestN, countDownMode, supplyOk, corrupt;
  logic [7:0] memData, cfgByte;
  logic [17:0] memAddr;
  logic memRead, cfgByteValid, userMode, configDone, errOut, errOe;
  int n_mismatch, cmp_count, idx;
  wire errPin = errOe ? errOut : 1'b1;
  sclint_loader uut (.clk_sys, .rst_b, .configRequestN, .countDownMode,
    .supplyOk, .memData, .memAddr, .memRead, .cfgByte, .cfgByteValid,
    .userMode, .configDone, .configErrorFlagNOut(errOut),
    .configErrorFlagNOe(errOe));
  sclint_mem_model mem (.memAddr, .memRead, .countDownMode, .corrupt,
    .memData);
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Mid-cycle sampling keeps clear of the launching edge
  always @(negedge clk_sys) if (cfgByteValid === 1'b1) begin
    `CHK(cfgByte, 8'(idx / 16 * 18 + idx % 16) ^ 8'h3c)
    idx++;
  end
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task restart(input logic m);
    configRequestN = 0;
    countDownMode = m;
    step(2);
    configRequestN = 1;
    idx = 0;
    for (int i = 0; i < 20 && !memRead; i++) step(1);
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task t_walk;
    restart(`SCLINT_MODE_UP);
    `CHK(memAddr, `SCLINT_ADDR_FIRST)
    step(60);
    `CHK(memAddr, 18'd60)
    `CHK(errPin, 1'b1)
    restart(`SCLINT_MODE_DOWN);
    `CHK(memAddr, `SCLINT_ADDR_LAST)
    step(40);
    `CHK(memAddr, 18'h3ffd7)
    $display("address walk done");
  endtask
  task t_crc;
    corrupt = 1;
    restart(`SCLINT_MODE_UP);
    step(16);
    `CHK(errPin, 1'b1)
    step(6);
    `CHK({errPin, memRead, userMode}, 3'h0)
    step(30);
    `CHK({errPin, configDone}, 2'h0)
    corrupt = 0;
    restart(`SCLINT_MODE_UP);
    `CHK({errPin, memAddr}, {1'b1, `SCLINT_ADDR_FIRST})
    $display("check mismatch done");
  endtask
  task t_supply;
    step(10);
    supplyOk = 0;
    step(1);
    `CHK(errPin, 1'b0)
    supplyOk = 1;
    step(20);
    `CHK({errPin, memRead}, 2'h0)
    restart(`SCLINT_MODE_DOWN);
    `CHK({errPin, memAddr}, {1'b1, `SCLINT_ADDR_LAST})
    $display("supply loss done");
  endtask
  initial begin
    {rst_b, countDownMode, corrupt, idx} = 0;
    {configRequestN, supplyOk} = 2'h3;
    repeat (16) @(posedge clk_sys);
    #1 rst_b = 1;
    step(2);
    `CHK(memRead, 1'b1)
    t_walk;
    t_crc;
    t_supply;
    end_of_test;
  end
  initial begin
    #100000;
    n_mismatch++;
    end_of_test;
  end
endmodule // test_sclint_loader

/* verilog/sclint_crc_byte.v */
// Byte-wide CRC update, most significant bit of the byte first
`include "sclint_consts.vh"
module sclint_crc_byte #(
  parameter CRC_W = `SCLINT_CRC_W,
  parameter [CRC_W-1:0] POLY = `SCLINT_CRC_POLY
) (
  input wire [CRC_W-1:0] crcIn, // Running check value
  input wire [7:0] dataIn, // Byte folded in
  output wire [CRC_W-1:0] crcOut // Updated check value
);
  wire [CRC_W-1:0] stage [0:8];
  assign stage[0] = crcIn;
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : gBit
      wire fb;
      assign fb = stage[i][CRC_W-1] ^ dataIn[7-i];
      assign stage[i+1] = {stage[i][CRC_W-2:0], 1'b0} ^ (fb ? POLY : {CRC_W{1'b0}});
    end
  endgenerate
  assign crcOut = stage[8];
endmodule // sclint_crc_byte

/* verilog/sclint_loader.v */
// Active parallel configuration loader with frame check and error latch
`include "sclint_consts.vh"
module sclint_loader #(
  parameter ADDR_W = `SCLINT_ADDR_W,
  parameter CRC_W = `SCLINT_CRC_W,
  parameter [15:0] FRAME_BYTES = `SCLINT_FRAME_BYTES,
  parameter [7:0] INIT_CYCLES = `SCLINT_INIT_CYCLES
) (
  input wire clk_sys, // System clock, 100 MHz
  input wire rst_b, // Asynchronous reset, active low
  input wire configRequestN, // Configuration request, active low
  input wire countDownMode, // Low: count up, high: count down
  input wire supplyOk, // High while supply holds stored data
  input wire [7:0] memData, // Byte from configuration memory
  output reg [ADDR_W-1:0] memAddr, // Memory address, base sequence
  output reg memRead, // Address valid, data taken next edge
  output reg [7:0] cfgByte, // Byte written into configuration cells
  output reg cfgByteValid, // Pulse per stored configuration byte
  output reg userMode, // Device operates as user logic
  output reg configDone, // Load and init finished cleanly
  output wire configErrorFlagNOut, // Error status pin level
  output wire configErrorFlagNOe // Error pin driver enable
);
  reg [2:0] state_reg, state_next;
  reg [ADDR_W-1:0] addr_reg, addr_next;
  reg dir_reg, dir_next;
  reg last_reg, last_next;
  reg [15:0] cnt_reg, cnt_next;
  reg [CRC_W-1:0] crc_reg, crc_next;
  reg [7:0] crcHi_reg, crcHi_next;
  reg [7:0] init_reg, init_next;
  reg err_reg, err_next;
  wire [CRC_W-1:0] crcUpd;
  wire [ADDR_W-1:0] addrStart;
  wire [ADDR_W-1:0] addrEnd;
  wire fetch;

  sclint_crc_byte #(.CRC_W(CRC_W)) uCrc (
    .crcIn(crc_reg),
    .dataIn(memData),
    .crcOut(crcUpd)
  );

  // Open-drain status pin: only ever pulls low
  assign configErrorFlagNOut = 1'b0;
  assign configErrorFlagNOe = err_reg;

  assign addrStart = (dir_reg == `SCLINT_MODE_DOWN) ?
    `SCLINT_ADDR_LAST : `SCLINT_ADDR_FIRST;
  assign addrEnd = (dir_reg == `SCLINT_MODE_DOWN) ?
    `SCLINT_ADDR_FIRST : `SCLINT_ADDR_LAST;
  assign fetch = (state_reg == `SCLINT_ST_DATA) ||
    (state_reg == `SCLINT_ST_CRCHI) || (state_reg == `SCLINT_ST_CRCLO);

  always @* begin
    state_next = state_reg;
    addr_next = addr_reg;
    dir_next = dir_reg;
    last_next = last_reg;
    cnt_next = cnt_reg;
    crc_next = crc_reg;
    crcHi_next = crcHi_reg;
    init_next = init_reg;
    err_next = err_reg;
    // Request low aborts everything and clears the error
    if (!configRequestN) begin
      state_next = `SCLINT_ST_IDLE;
      err_next = 1'b0;
    // Supply loss stops operation and flags it
    end else if (!supplyOk) begin
      state_next = `SCLINT_ST_ERROR;
      err_next = 1'b1;
    end else begin
      case (state_reg)
        `SCLINT_ST_IDLE: begin
          // Request tied high starts a load automatically
          dir_next = countDownMode;
          addr_next = (countDownMode == `SCLINT_MODE_DOWN) ?
            `SCLINT_ADDR_LAST : `SCLINT_ADDR_FIRST;
          last_next = 1'b0;
          cnt_next = 16'h0000;
          crc_next = `SCLINT_CRC_INIT;
          state_next = `SCLINT_ST_DATA;
        end
        `SCLINT_ST_DATA: begin
          // Fold each data byte into the frame check
          crc_next = crcUpd;
          cnt_next = cnt_reg + 16'h0001;
          if (cnt_reg == FRAME_BYTES - 16'h0001) begin
            state_next = `SCLINT_ST_CRCHI;
          end
        end
        `SCLINT_ST_CRCHI: begin
          crcHi_next = memData;
          state_next = `SCLINT_ST_CRCLO;
        end
        `SCLINT_ST_CRCLO: begin
          cnt_next = 16'h0000;
          crc_next = `SCLINT_CRC_INIT;
          // Mismatch halts loading and latches the error
          if ({crcHi_reg, memData} != crc_reg) begin
            state_next = `SCLINT_ST_ERROR;
            err_next = 1'b1;
          end else if (last_reg) begin
            init_next = 8'h00;
            state_next = `SCLINT_ST_INIT;
          end else begin
            state_next = `SCLINT_ST_DATA;
          end
        end
        `SCLINT_ST_INIT: begin
          init_next = init_reg + 8'h01;
          if (init_reg == INIT_CYCLES - 8'h01) begin
            state_next = `SCLINT_ST_USER;
          end
        end
        `SCLINT_ST_USER: begin
          // Download side is ignored in user mode
          state_next = `SCLINT_ST_USER;
        end
        `SCLINT_ST_ERROR: begin
          // Stays here until a fresh request
          state_next = `SCLINT_ST_ERROR;
        end
        default: begin
          state_next = `SCLINT_ST_IDLE;
        end
      endcase
      // Step the address once per fetched byte
      if (fetch && !last_reg) begin
        if (addr_reg == addrEnd) begin
          last_next = 1'b1;
        end else if (dir_reg == `SCLINT_MODE_DOWN) begin
          addr_next = addr_reg - {{(ADDR_W-1){1'b0}}, 1'b1};
        end else begin
          addr_next = addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
        end
      end
      // Range exhausted mid-frame: finish with the pending check
      if (state_reg == `SCLINT_ST_DATA && last_reg) begin
        state_next = `SCLINT_ST_CRCHI;
      end
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= `SCLINT_ST_IDLE;
      addr_reg <= `SCLINT_ADDR_FIRST;
      dir_reg <= `SCLINT_MODE_UP;
      last_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      crc_reg <= `SCLINT_CRC_INIT;
      crcHi_reg <= 8'h00;
      init_reg <= 8'h00;
      err_reg <= 1'b0;
      memAddr <= `SCLINT_ADDR_FIRST;
      memRead <= 1'b0;
      cfgByte <= 8'h00;
      cfgByteValid <= 1'b0;
      userMode <= 1'b0;
      configDone <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      dir_reg <= dir_next;
      last_reg <= last_next;
      cnt_reg <= cnt_next;
      crc_reg <= crc_next;
      crcHi_reg <= crcHi_next;
      init_reg <= init_next;
      err_reg <= err_next;
      memAddr <= addr_next;
      memRead <= (state_next == `SCLINT_ST_DATA) ||
        (state_next == `SCLINT_ST_CRCHI) || (state_next == `SCLINT_ST_CRCLO);
      // Bytes only reach the cells while loading is healthy
      cfgByte <= memData;
      cfgByteValid <= (state_reg == `SCLINT_ST_DATA) && configRequestN &&
        supplyOk;
      // User mode only from a clean load
      userMode <= (state_next == `SCLINT_ST_USER);
      configDone <= (state_next == `SCLINT_ST_USER);
    end
  end
endmodule // sclint_loader
